//--- verilog/tdm_slot_pkg.sv
// constants, field layout and types of the timeslot data access block
package tdm_slot_pkg;

  // ----------------------------------------------------------------
  // frame structure
  // ----------------------------------------------------------------
  localparam logic [7:0] FRAME_BITS  = 8'h60;  // 12 slots of 8 bits
  localparam logic [7:0] HALF_LAST   = 8'hBF;  // last double-rate edge
  localparam logic [7:0] SLOT_BITS   = 8'h08;
  localparam logic [7:0] DLY_LINE0   = 8'h02;  // bit periods after slot
  localparam logic [7:0] DLY_LINE1   = 8'h01;
  localparam logic [3:0] MON_SLOT    = 4'hB;   // bus access channel

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DATA0   = 8'h00;  // four data registers
  localparam logic [7:0] OFS_SELECT0 = 8'h10;  // four slot/line selects
  localparam logic [7:0] OFS_CTRL1   = 8'h20;
  localparam logic [7:0] OFS_CTRL2   = 8'h24;
  localparam logic [7:0] OFS_MASK    = 8'h28;
  localparam logic [7:0] OFS_STATUS  = 8'h2C;
  localparam logic [7:0] OFS_ACK     = 8'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LINE_BIT     = 7;   // select: 0 out downstream, 1 out upstream
  localparam int CTRL_IN_EN0  = 0;
  localparam int CTRL_OUT_EN0 = 1;
  localparam int CTRL_IN_EN1  = 2;
  localparam int CTRL_OUT_EN1 = 3;
  localparam int CTRL_SWAP    = 4;
  localparam int CTRL_MON     = 5;
  localparam int SYNC_OVERFLOW_IRQ_LSB     = 4;   // mask and status: [3:0] transfer, [7:4] overflow

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DATA   = 8'hFF;  // idle line level
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [5:0] RST_CTRL   = 6'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;

  typedef struct packed {
    logic [3:0] out_slot;
    logic       out_line;
    logic [3:0] in_slot;
    logic       in_line;
    logic       in_en;
    logic       out_en;
  } chan_cfg_type;

endpackage

//--- verilog/frame_timing_if.sv
// frame bit timing shared by the top and the four slot channels
`timescale 1ns/10ps
interface frame_timing_if;
  logic       bit_stb;   // start of bit bit_idx, drive edge
  logic       samp_stb;  // sample point of bit bit_idx
  logic [6:0] bit_idx;
  logic       up_level;
  logic       dn_level;

  modport source (output bit_stb, output samp_stb, output bit_idx,
                  output up_level, output dn_level);
  modport sink   (input bit_stb, input samp_stb, input bit_idx,
                  input up_level, input dn_level);
endinterface

//--- verilog/slot_channel.sv
// one timeslot data register with its capture, output and event timing
`timescale 1ns/10ps
module slot_channel
(
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  frame_timing_if.sink                    ft,
  input  wire tdm_slot_pkg::chan_cfg_type cfg_i,
  input  wire logic                       wr_i,
  input  wire logic [7:0]                 wr_data_i,
  output logic [7:0]                      data_o,
  output logic                            drive_en_o,
  output logic                            drive_val_o,
  output logic                            sti_evt_o,
  output logic                            deadline_evt_o
);

  typedef struct packed {
    logic [7:0] shift_in;
    logic [7:0] data;
    logic [7:0] out_sh;
    logic       driving;
    logic       sync_transfer_irq;
    logic       deadline;
  } chan_state_type;

  chan_state_type st_r;
  chan_state_type st_nxt;

  // bit position a few bit periods after the end of a slot
  function automatic logic [6:0] after_slot(input logic [3:0] s, input logic line);
    logic [7:0] p;
    p = {1'b0, s, 3'h0} + tdm_slot_pkg::SLOT_BITS
        + (line ? tdm_slot_pkg::DLY_LINE1 : tdm_slot_pkg::DLY_LINE0);
    return (p >= tdm_slot_pkg::FRAME_BITS) ? 7'(p - tdm_slot_pkg::FRAME_BITS) : p[6:0];
  endfunction

  // last acknowledge point ahead of the slot's next occurrence
  function automatic logic [6:0] before_slot(input logic [3:0] s, input logic line);
    logic [7:0] p;
    p = {1'b0, s, 3'h0} + tdm_slot_pkg::FRAME_BITS
        - (line ? tdm_slot_pkg::DLY_LINE1 : tdm_slot_pkg::DLY_LINE0);
    return (p >= tdm_slot_pkg::FRAME_BITS) ? 7'(p - tdm_slot_pkg::FRAME_BITS) : p[6:0];
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic in_bit;
    in_bit = cfg_i.in_line ? ft.dn_level : ft.up_level;
    st_nxt = st_r;
    st_nxt.sync_transfer_irq = 1'b0;
    st_nxt.deadline = 1'b0;
    if (ft.samp_stb && cfg_i.in_en && ft.bit_idx[6:3] == cfg_i.in_slot)
    begin
      st_nxt.shift_in = {st_r.shift_in[6:0], in_bit};
    end
    if (ft.bit_stb)
    begin
      // commit late so an adjacent target slot goes out next frame
      if (cfg_i.in_en && ft.bit_idx == after_slot(cfg_i.in_slot, cfg_i.in_line))
      begin
        st_nxt.data = st_r.shift_in;
      end
      if (cfg_i.in_en && ft.bit_idx == after_slot(cfg_i.out_slot, cfg_i.out_line))
      begin
        st_nxt.sync_transfer_irq = 1'b1;
      end
      if (cfg_i.out_en && ft.bit_idx == before_slot(cfg_i.out_slot, cfg_i.out_line))
      begin
        st_nxt.deadline = 1'b1;
      end
      if (ft.bit_idx[6:3] == cfg_i.out_slot)
      begin
        st_nxt.driving = cfg_i.out_en;
        st_nxt.out_sh = (ft.bit_idx[2:0] == 3'h0) ? st_r.data
                                                  : {st_r.out_sh[6:0], 1'b1};
      end
      else
      begin
        st_nxt.driving = 1'b0;
      end
    end
    // a bus write wins over a capture commit in the same cycle
    if (wr_i)
    begin
      st_nxt.data = wr_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '{shift_in: tdm_slot_pkg::RST_DATA, data: tdm_slot_pkg::RST_DATA,
                out_sh: tdm_slot_pkg::RST_DATA, driving: 1'b0, sync_transfer_irq: 1'b0,
                deadline: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign data_o         = st_r.data;
  assign drive_en_o     = st_r.driving;
  assign drive_val_o    = st_r.out_sh[7];
  assign sti_evt_o      = st_r.sync_transfer_irq;
  assign deadline_evt_o = st_r.deadline;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_sti_moment;
    @(posedge clk_i) disable iff (sys_rst_i)
    st_nxt.sync_transfer_irq |-> ft.bit_stb && ({1'b0, ft.bit_idx} ==
      (({4'h0, cfg_i.out_slot} == 8'h0B)
        ? (cfg_i.out_line ? 8'h01 : 8'h02)
        : ({1'b0, cfg_i.out_slot, 3'h0} + (cfg_i.out_line ? 8'h09 : 8'h0A))));
  endproperty
  a_sti_moment: assert property (p_sti_moment) else $error("transfer event off slot");

endmodule // slot_channel

//--- verilog/tdm_slot_data_access.sv
// timeslot data access: four slot data registers on a framed serial bus
// How it works
// - each register picks one slot 0..11
// - line bit picks output line, input opposite
// - output slot/line always from own select
// - swap off: input from own select
// - swap on: inputs cross within pair
// - separate input/output enables; disabled input holds
// - looped data leaves one frame later
// - shift same frame only if b>=a+2
// - looping runs alone; access between events
// - monitor enable forces first register of its pair to input slot 11
// - transfer event two/one bit periods after slot
// - overflow tied to own unacknowledged transfer
// - own transfer masked: overflow for any other
// - no transfer enabled, no event at all
// - both enabled: overflow only for own
// - transfer event needs input enabled
// - overflow event needs output enabled
// - acknowledged in time: no overflow
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module tdm_slot_data_access
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        frame_sync_i,
  input  wire logic        double_rate_clock_i,
  input  wire logic        upstream_line_i,
  output logic             upstream_line_o,
  output logic             upstream_line_oe_n_o,
  input  wire logic        downstream_line_i,
  output logic             downstream_line_o,
  output logic             downstream_line_oe_n_o
);

  typedef struct packed {
    logic [2:0]      sync_fsc;
    logic [2:0]      sync_dcl;
    logic [2:0]      sync_up;
    logic [2:0]      sync_dn;
    logic            fsc_lv;
    logic            dcl_lv;
    logic            up_lv;
    logic            dn_lv;
    logic            framed;
    logic [7:0]      half_cnt;
    logic            bit_stb;
    logic            samp_stb;
    logic [6:0]      bit_idx;
    logic [3:0][7:0] select;
    logic [1:0][5:0] ctrl;
    logic [7:0]      mask;
    logic [7:0]      status;
    logic [3:0]      pending;
    logic            ph_valid;
    logic            ph_write;
    logic [7:0]      ph_addr;
    logic [31:0]     rdata;
    logic            up_o;
    logic            up_oe_n;
    logic            dn_o;
    logic            dn_oe_n;
  } top_state_type;

  top_state_type st_r;
  top_state_type st_nxt;

  frame_timing_if ft ();

  tdm_slot_pkg::chan_cfg_type cfg [4];
  logic [3:0][7:0] chan_data;
  logic [3:0]      drv_en;
  logic [3:0]      drv_val;
  logic [3:0]      sti_evt;
  logic [3:0]      dl_evt;
  logic [3:0]      wr_data_sel;
  logic [3:0]      sti_gen;
  logic [3:0]      unacked;
  logic [3:0]      ov_gen;
  logic            wr_phase;

  assign ft.bit_stb  = st_r.bit_stb;
  assign ft.samp_stb = st_r.samp_stb;
  assign ft.bit_idx  = st_r.bit_idx;
  assign ft.up_level = st_r.up_lv;
  assign ft.dn_level = st_r.dn_lv;

  assign wr_phase = st_r.ph_valid && st_r.ph_write;

  // ----------------------------------------------------------------
  // channel configuration and the four channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_chan
    localparam int P   = i / 2;
    localparam int SEC = i % 2;
    logic [1:0] src;
    logic       mon;
    assign mon = st_r.ctrl[P][tdm_slot_pkg::CTRL_MON] && (SEC == 0);
    assign src = st_r.ctrl[P][tdm_slot_pkg::CTRL_SWAP] ? 2'(i ^ 1) : 2'(i);
    assign cfg[i].out_slot = st_r.select[i][3:0];
    assign cfg[i].out_line = st_r.select[i][tdm_slot_pkg::LINE_BIT];
    assign cfg[i].in_slot  = mon ? tdm_slot_pkg::MON_SLOT : st_r.select[src][3:0];
    assign cfg[i].in_line  = st_r.select[src][tdm_slot_pkg::LINE_BIT];
    assign cfg[i].in_en    = st_r.ctrl[P][2 * SEC];
    assign cfg[i].out_en   = st_r.ctrl[P][2 * SEC + 1];
    assign wr_data_sel[i]  = wr_phase && (st_r.ph_addr == tdm_slot_pkg::OFS_DATA0 + 8'(4 * i));

    slot_channel u_chan
    (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .ft             (ft.sink),
      .cfg_i          (cfg[i]),
      .wr_i           (wr_data_sel[i]),
      .wr_data_i      (hwdata_i[7:0]),
      .data_o         (chan_data[i]),
      .drive_en_o     (drv_en[i]),
      .drive_val_o    (drv_val[i]),
      .sti_evt_o      (sti_evt[i]),
      .deadline_evt_o (dl_evt[i])
    );
  end

  // ----------------------------------------------------------------
  // transfer and overflow events
  // ----------------------------------------------------------------
  always_comb
  begin
    sti_gen = sti_evt & st_r.mask[3:0];
    unacked = dl_evt & st_r.pending;
    for (int k = 0; k < 4; k++)
    begin
      if (!(st_r.mask[tdm_slot_pkg::SYNC_OVERFLOW_IRQ_LSB + k] && cfg[k].out_en))
        ov_gen[k] = 1'b0;
      else if (st_r.mask[k])
        ov_gen[k] = unacked[k];
      else
        ov_gen[k] = |(unacked & ~(4'h1 << k));
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       fsc_rise;
    logic       dcl_rise;
    logic       dcl_fall;
    logic [7:0] base;
    logic [7:0] cnt;
    logic [3:0] ack_clr;
    logic [7:0] st_clr;
    fsc_rise = 1'b0;
    dcl_rise = 1'b0;
    dcl_fall = 1'b0;
    base = 8'h00;
    cnt = 8'h00;
    ack_clr = 4'h0;
    st_clr = 8'h00;
    st_nxt = st_r;

    // three-stage sampling; a change counts when stages two and three agree
    st_nxt.sync_fsc = {st_r.sync_fsc[1:0], frame_sync_i};
    st_nxt.sync_dcl = {st_r.sync_dcl[1:0], double_rate_clock_i};
    st_nxt.sync_up  = {st_r.sync_up[1:0], upstream_line_i};
    st_nxt.sync_dn  = {st_r.sync_dn[1:0], downstream_line_i};
    if (st_r.sync_fsc[1] == st_r.sync_fsc[2]) st_nxt.fsc_lv = st_r.sync_fsc[2];
    if (st_r.sync_dcl[1] == st_r.sync_dcl[2]) st_nxt.dcl_lv = st_r.sync_dcl[2];
    if (st_r.sync_up[1] == st_r.sync_up[2]) st_nxt.up_lv = st_r.sync_up[2];
    if (st_r.sync_dn[1] == st_r.sync_dn[2]) st_nxt.dn_lv = st_r.sync_dn[2];
    fsc_rise = st_nxt.fsc_lv && !st_r.fsc_lv;
    dcl_rise = st_nxt.dcl_lv && !st_r.dcl_lv;
    dcl_fall = !st_nxt.dcl_lv && st_r.dcl_lv;

    // bit timing: drive on first rising edge, sample on second falling
    st_nxt.bit_stb  = 1'b0;
    st_nxt.samp_stb = 1'b0;
    base = fsc_rise ? 8'hFF : st_r.half_cnt;
    if (fsc_rise) st_nxt.framed = 1'b1;
    if (fsc_rise) st_nxt.half_cnt = base;
    if (dcl_rise && (st_r.framed || fsc_rise))
    begin
      cnt = (base == tdm_slot_pkg::HALF_LAST) ? 8'h00 : 8'(base + 8'h01);
      st_nxt.half_cnt = cnt;
      if (!cnt[0])
      begin
        st_nxt.bit_stb = 1'b1;
        st_nxt.bit_idx = cnt[7:1];
      end
    end
    else if (dcl_fall && st_r.framed && st_r.half_cnt[0])
    begin
      st_nxt.samp_stb = 1'b1;
      st_nxt.bit_idx  = st_r.half_cnt[7:1];
    end

    // line drivers, lowest channel first; idle lines are released
    st_nxt.up_o = 1'b1;
    st_nxt.up_oe_n = 1'b1;
    st_nxt.dn_o = 1'b1;
    st_nxt.dn_oe_n = 1'b1;
    for (int i = 3; i >= 0; i--)
    begin
      if (drv_en[i] && cfg[i].out_line)
      begin
        st_nxt.up_o = drv_val[i];
        st_nxt.up_oe_n = 1'b0;
      end
      if (drv_en[i] && !cfg[i].out_line)
      begin
        st_nxt.dn_o = drv_val[i];
        st_nxt.dn_oe_n = 1'b0;
      end
    end

    // bus data phase: word writes only, hsize not checked
    if (wr_phase)
    begin
      if (st_r.ph_addr[7:4] == tdm_slot_pkg::OFS_SELECT0[7:4])
        st_nxt.select[st_r.ph_addr[3:2]] = hwdata_i[7:0];
      if (st_r.ph_addr == tdm_slot_pkg::OFS_CTRL1) st_nxt.ctrl[0] = hwdata_i[5:0];
      if (st_r.ph_addr == tdm_slot_pkg::OFS_CTRL2) st_nxt.ctrl[1] = hwdata_i[5:0];
      if (st_r.ph_addr == tdm_slot_pkg::OFS_MASK) st_nxt.mask = hwdata_i[7:0];
      if (st_r.ph_addr == tdm_slot_pkg::OFS_STATUS) st_clr = hwdata_i[7:0];
      if (st_r.ph_addr == tdm_slot_pkg::OFS_ACK) ack_clr = hwdata_i[3:0];
    end
    // hardware set wins over a same-cycle clear
    st_nxt.status  = (st_r.status & ~st_clr) | {ov_gen, sti_gen};
    st_nxt.pending = (st_r.pending & ~ack_clr) | sti_gen;

    // bus address phase; read data is captured here, zero wait states
    st_nxt.ph_valid = hsel_i && hready_i && htrans_i[1];
    st_nxt.ph_write = hwrite_i;
    st_nxt.ph_addr  = haddr_i[7:0];
    if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
    begin
      st_nxt.rdata = 32'h0000_0000;
      if (haddr_i[7:4] == tdm_slot_pkg::OFS_DATA0[7:4])
        st_nxt.rdata = {24'h00_0000, chan_data[haddr_i[3:2]]};
      if (haddr_i[7:4] == tdm_slot_pkg::OFS_SELECT0[7:4])
        st_nxt.rdata = {24'h00_0000, st_r.select[haddr_i[3:2]]};
      if (haddr_i[7:0] == tdm_slot_pkg::OFS_CTRL1) st_nxt.rdata = {26'h0, st_r.ctrl[0]};
      if (haddr_i[7:0] == tdm_slot_pkg::OFS_CTRL2) st_nxt.rdata = {26'h0, st_r.ctrl[1]};
      if (haddr_i[7:0] == tdm_slot_pkg::OFS_MASK) st_nxt.rdata = {24'h00_0000, st_r.mask};
      if (haddr_i[7:0] == tdm_slot_pkg::OFS_STATUS) st_nxt.rdata = {24'h00_0000, st_r.status};
      if (haddr_i[7:0] == tdm_slot_pkg::OFS_ACK) st_nxt.rdata = {28'h000_0000, st_r.pending};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
      st_r.half_cnt <= 8'hFF;
      st_r.select <= {4{tdm_slot_pkg::RST_SELECT}};
      st_r.ctrl <= {2{tdm_slot_pkg::RST_CTRL}};
      st_r.mask <= tdm_slot_pkg::RST_MASK;
      st_r.up_o <= 1'b1;
      st_r.up_oe_n <= 1'b1;
      st_r.dn_o <= 1'b1;
      st_r.dn_oe_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hrdata_o               = st_r.rdata;
  assign hreadyout_o            = 1'b1;
  assign hresp_o                = 1'b0;
  assign upstream_line_o        = st_r.up_o;
  assign upstream_line_oe_n_o   = st_r.up_oe_n;
  assign downstream_line_o      = st_r.dn_o;
  assign downstream_line_oe_n_o = st_r.dn_oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_sti_needs_input;
    $rose(st_r.status[0]) |-> $past(cfg[0].in_en && sti_evt[0]);
  endproperty
  a_sti_needs_input: assert property (p_sti_needs_input) else $error("transfer flag without input");

  property p_ov_needs_output;
    $rose(st_r.status[4]) |-> $past(cfg[0].out_en);
  endproperty
  a_ov_needs_output: assert property (p_ov_needs_output) else $error("overflow without output");

  property p_quiet_when_unmasked;
    (st_r.mask[3:0] == 4'h0 && st_r.pending == 4'h0) |=> (st_r.status & ~$past(st_r.status)) == 8'h00;
  endproperty
  a_quiet_when_unmasked: assert property (p_quiet_when_unmasked) else $error("event with no transfer enabled");

  property p_own_overflow;
    ($rose(st_r.status[4]) && $past(st_r.mask[0])) |-> $past(dl_evt[0] && st_r.pending[0]);
  endproperty
  a_own_overflow: assert property (p_own_overflow) else $error("overflow not from own transfer");

  property p_other_overflow;
    ($rose(st_r.status[4]) && !$past(st_r.mask[0])) |-> $past(|(dl_evt & st_r.pending & 4'hE));
  endproperty
  a_other_overflow: assert property (p_other_overflow) else $error("overflow without other pending");

  property p_acked_quiet;
    (dl_evt[1] && !st_r.pending[1] && st_r.mask[1]) |=> !$rose(st_r.status[5]);
  endproperty
  a_acked_quiet: assert property (p_acked_quiet) else $error("overflow after acknowledge");

  property p_bus_write;
    wr_data_sel[0] |=> chan_data[0] == $past(hwdata_i[7:0]);
  endproperty
  a_bus_write: assert property (p_bus_write) else $error("data write lost");

  property p_hold_disabled;
    (!cfg[0].in_en && !wr_data_sel[0]) |=> $stable(chan_data[0]);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("disabled data changed");

  property p_swap_inputs;
    (st_r.ctrl[0][tdm_slot_pkg::CTRL_SWAP] && !st_r.ctrl[0][tdm_slot_pkg::CTRL_MON])
      |-> cfg[0].in_slot == st_r.select[1][3:0] && cfg[1].in_slot == st_r.select[0][3:0]
          && cfg[0].out_slot == st_r.select[0][3:0];
  endproperty
  a_swap_inputs: assert property (p_swap_inputs) else $error("swap crossing wrong");

  property p_monitor_slot;
    st_r.ctrl[1][tdm_slot_pkg::CTRL_MON] |-> cfg[2].in_slot == 4'hB;
  endproperty
  a_monitor_slot: assert property (p_monitor_slot) else $error("monitor not on slot 11");

  property p_line_drive;
    (drv_en[0] && !cfg[0].out_line) |=> !downstream_line_oe_n_o;
  endproperty
  a_line_drive: assert property (p_line_drive) else $error("downstream not driven");

  c_sti:   cover property ($rose(st_r.status[0]));
  c_ov:    cover property ($rose(st_r.status[4]));
  c_swap:  cover property (st_r.ctrl[0][tdm_slot_pkg::CTRL_SWAP] && sti_evt[1]);
  c_drive: cover property (!upstream_line_oe_n_o ##1 upstream_line_oe_n_o);

endmodule // tdm_slot_data_access

//--- testbench/frame_bus_source.sv
// behavioural frame bus partner: free-running clocks, sync, one slot each way
`timescale 1ns/10ps
module frame_bus_source
#(
  parameter int SLOT = 2
)
(
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       dn_line_i,
  output logic            dcl_o,
  output logic            fsc_o,
  output logic            up_o,
  output logic [7:0]      rx_byte_o
);
  int         rise_n = 0;
  logic [7:0] sh = 8'hFF;
  initial dcl_o = 1'b0;
  initial fsc_o = 1'b0;
  initial up_o = 1'b1;
  initial rx_byte_o = 8'hFF;
  // bus clocks keep running through reset
  always #40 dcl_o = ~dcl_o;
  always @(posedge dcl_o)
  begin
    fsc_o  <= (rise_n == 191) || (rise_n == 0);
    // own slot only, elsewhere the pull-up holds the line
    up_o   <= (rise_n / 16 == SLOT) ? tx_byte_i[7 - (rise_n / 2) % 8] : 1'b1;
    rise_n <= (rise_n + 1) % 192;
  end
  // sample late in each bit; publish whole bytes only
  always @(negedge dcl_o)
  begin
    if (rise_n % 2 == 0 && (rise_n - 2) / 16 == SLOT)
    begin
      sh <= {sh[6:0], dn_line_i};
      if ((rise_n - 2) % 16 == 14)
        rx_byte_o <= {sh[6:0], dn_line_i};
    end
  end
endmodule // frame_bus_source

//--- testbench/test_tdm_slot_data_access.sv
// self-checking bench: register access, slot looping and transfer events
`timescale 1ns/10ps
module test_tdm_slot_data_access;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        double_rate_clock, frame_sync, up_src, up_o, up_oe_n, dn_o, dn_oe_n;
  logic [7:0]  rx_byte;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // open-drain style lines with pull-ups
  wire         up_wire = up_oe_n ? up_src : (up_src & up_o);
  wire         dn_wire = dn_oe_n ? 1'b1 : dn_o;

  always #5 clk_i = ~clk_i;

  tdm_slot_data_access i_tdm_slot_data_access (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(), .frame_sync_i(frame_sync), .double_rate_clock_i(double_rate_clock), .upstream_line_i(up_wire),
    .upstream_line_o(up_o), .upstream_line_oe_n_o(up_oe_n), .downstream_line_i(dn_wire),
    .downstream_line_o(dn_o), .downstream_line_oe_n_o(dn_oe_n));

  frame_bus_source i_frame_bus_source (.tx_byte_i(8'hA5), .dn_line_i(dn_wire),
    .dcl_o(double_rate_clock), .fsc_o(frame_sync), .up_o(up_src), .rx_byte_o(rx_byte));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single AHB transfer; waits for hready in both phases
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    xfer(1'b0, tdm_slot_pkg::OFS_DATA0, 32'h0);
    chk(rd, {24'h0, tdm_slot_pkg::RST_DATA});
    xfer(1'b1, 8'h0C, 32'h3C);
    xfer(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h3C);
    xfer(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask

  // slot 2 taken from upstream, looped to downstream, never acknowledged
  task t_loop;
    xfer(1'b1, tdm_slot_pkg::OFS_SELECT0, 32'h02);
    xfer(1'b1, tdm_slot_pkg::OFS_CTRL1, 32'h03);
    xfer(1'b1, tdm_slot_pkg::OFS_MASK, 32'h11);
    repeat (3 * 1536) @(posedge clk_i);
    chk({24'h0, rx_byte}, 32'hA5);
    xfer(1'b0, tdm_slot_pkg::OFS_DATA0, 32'h0);
    chk(rd, 32'hA5);
    xfer(1'b0, tdm_slot_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h11);
    $display("test loop done");
  endtask

  // acknowledged inside the window: no overflow follows
  task t_ack;
    xfer(1'b1, tdm_slot_pkg::OFS_STATUS, 32'hFF);
    rd = 32'h0;
    while (rd[0] !== 1'b1)
      xfer(1'b0, tdm_slot_pkg::OFS_STATUS, 32'h0);
    xfer(1'b1, tdm_slot_pkg::OFS_ACK, 32'h01);
    // also drop an overflow left by the unacknowledged frames before
    xfer(1'b1, tdm_slot_pkg::OFS_STATUS, 32'hFF);
    repeat (1536) @(posedge clk_i);
    xfer(1'b0, tdm_slot_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h10, 32'h0);
    $display("test ack done");
  endtask

  // overflow enabled with no transfer enabled stays silent
  task t_quiet;
    xfer(1'b1, tdm_slot_pkg::OFS_MASK, 32'h10);
    xfer(1'b1, tdm_slot_pkg::OFS_ACK, 32'h0F);
    xfer(1'b1, tdm_slot_pkg::OFS_STATUS, 32'hFF);
    repeat (2 * 1536) @(posedge clk_i);
    xfer(1'b0, tdm_slot_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test quiet done");
  endtask

  // bus access channel monitor: first register captures idle slot 11
  task t_monitor;
    xfer(1'b1, tdm_slot_pkg::OFS_SELECT0, 32'h08);
    xfer(1'b1, tdm_slot_pkg::OFS_CTRL1, 32'h21);
    repeat (2 * 1536) @(posedge clk_i);
    xfer(1'b0, tdm_slot_pkg::OFS_DATA0, 32'h0);
    chk(rd, {24'h0, tdm_slot_pkg::RST_DATA});
    $display("test monitor done");
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      stop_test;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_loop;
    t_ack;
    t_quiet;
    t_monitor;
    stop_test;
  end
endmodule // test_tdm_slot_data_access
